//--- include/osc_regs.vh
`ifndef OSC_REGS_VH
`define OSC_REGS_VH

// ==========================================================
// Register byte offsets
`define OSC_A_ENABLE      8'h00
`define OSC_A_LP_CFG      8'h04
`define OSC_A_HF_CFG      8'h08
`define OSC_A_FLAGS       8'h0c
`define OSC_A_IE          8'h10
`define OSC_A_KEY         8'h14
`define OSC_A_STATUS      8'h18

// ==========================================================
// Enable register bits (boot, low-power, high-freq, external)
`define OSC_EN_BOOT       0
`define OSC_EN_LP         1
`define OSC_EN_HF         2
`define OSC_EN_EXT        3
`define OSC_EN_RST        4'h1

// ==========================================================
// Low-power configuration fields
`define OSC_LP_TYPE       0
`define OSC_LP_WT_LSB     4
`define OSC_LP_NGAIN_LSB  8
`define OSC_LP_CAP_LSB    12
`define OSC_LP_BGAIN_LSB  16
`define OSC_LP_BOOST      20
`define OSC_LP_STOPDET    24
`define OSC_LP_RESTART    25

// ==========================================================
// High-frequency configuration fields
`define OSC_HF_FQ         0
`define OSC_HF_WT_LSB     4

// ==========================================================
// Event flag / enable bits
`define OSC_F_BOOT        0
`define OSC_F_LP          1
`define OSC_F_HF          2
`define OSC_F_STOP        3

// ==========================================================
// Protection and timing
`define OSC_KEY_UNLOCK    16'h0096
`define OSC_KEY_RST       16'h0000
`define OSC_BOOT_WAIT     15'h0010
`define OSC_LP_WAIT_LONG  15'h4000
`define OSC_LP_WAIT_1     15'h1000
`define OSC_LP_WAIT_2     15'h0800
`define OSC_LP_WAIT_3     15'h0400
`define OSC_HF_WAIT_BASE  15'h0004
`define OSC_LP_BOOST_CYC  15'h0400
// Stop timeout: 131072 ns counted in 4 ns clock cycles
`define OSC_STOP_CYCLES   16'h8000

`endif

//--- src/osc_start_ctrl.v
`default_nettype none
`include "osc_regs.vh"

// What this block does
// - Boot oscillator enabled and usable after reset
// - Low-power type: crystal or internal, software chosen
// - Boost bit gives high gain to the crystal only, fixed period
// - Crystal stop detector flags and restarts oscillator
// - One bit selects high-frequency output frequency
// - External clock passes at once when enabled
// - Clock gated until wait time elapses
// - Wait fields: 2-bit low-power, 3-bit high-freq
// - Boot oscillator wait fixed at 16 cycles
// - Wait end sets flag and opens clock
// - Full wait on every start, flag regardless
// - Flags cleared by writing one
// - Per-flag interrupt enable bit
// - Per-oscillator enable bit in one register
// - Configuration writes only while key unlocks
// - Low-power configuration field set
// - Interrupt only when flag and enable set
module osc_start_ctrl #(
    // Benches shorten these two; hardware keeps the defaults
    parameter [14:0] LP_WAIT_LONG = `OSC_LP_WAIT_LONG,
    parameter [15:0] STOP_CYCLES  = `OSC_STOP_CYCLES
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    input  wire        boot_osc_clock,
    input  wire        lowpower_osc_clock,
    input  wire        highfreq_osc_clock,
    output wire        boot_osc_run,
    output wire        lowpower_osc_run,
    output wire        highfreq_osc_run,
    output wire        lowpower_type_sel,
    output wire [1:0]  lowpower_gain,
    output wire [2:0]  gate_cap_sel,
    output wire        highfreq_freq_sel,
    output wire        boot_clk_gate,
    output wire        lowpower_clk_gate,
    output wire        highfreq_clk_gate,
    output wire        ext_clk_gate,
    output wire        irq
);

    // ==========================================================
    // Register state
    reg  [3:0]  en_q;
    reg         lp_type_q;
    reg  [1:0]  lp_wt_q;
    reg  [1:0]  lp_ngain_q;
    reg  [2:0]  lp_cap_q;
    reg  [1:0]  lp_bgain_q;
    reg         lp_boost_q;
    reg         lp_stopdet_q;
    reg         lp_restart_q;
    reg         hf_fq_q;
    reg  [2:0]  hf_wt_q;
    reg  [3:0]  flag_q;
    reg  [3:0]  ie_q;
    reg  [15:0] key_q;
    reg  [31:0] rdata_q;
    reg  [2:0]  run_q;
    reg         ext_gate_q;
    reg  [1:0]  gain_q;
    reg         irq_q;
    reg  [15:0] stop_cnt_q;
    reg  [3:0]  flag_d;
    reg  [31:0] rdata_d;
    reg  [14:0] lp_tgt;

    // ==========================================================
    // Shared wires
    // Three counted oscillators; the external input has no wait
    localparam NWAIT = 3;
    localparam CW    = 15;

    wire [2:0]  osc_clk_in;
    wire [2:0]  osc_edge;
    wire [2:0]  gate_q;
    wire [2:0]  done;
    wire [44:0] tgt;
    wire [44:0] cnt_all;
    wire [14:0] lp_cnt;
    wire        unlocked;
    wire        stop_evt;
    wire        boost_on;

    // One write strobe per writable register
    wire wr_en  = reg_wr & (reg_addr == `OSC_A_ENABLE);
    wire wr_lp  = reg_wr & (reg_addr == `OSC_A_LP_CFG);
    wire wr_hf  = reg_wr & (reg_addr == `OSC_A_HF_CFG);
    wire wr_flg = reg_wr & (reg_addr == `OSC_A_FLAGS);
    wire wr_ie  = reg_wr & (reg_addr == `OSC_A_IE);
    wire wr_key = reg_wr & (reg_addr == `OSC_A_KEY);

    assign unlocked   = (key_q == `OSC_KEY_UNLOCK);
    assign osc_clk_in = {highfreq_osc_clock, lowpower_osc_clock, boot_osc_clock};

    // ==========================================================
    // Wait lengths per oscillator, counted in its own cycles
    // Code 0 is the crystal minimum, code 1 the internal minimum
    always @* begin
        case (lp_wt_q)
            2'b00:   lp_tgt = LP_WAIT_LONG;
            2'b01:   lp_tgt = `OSC_LP_WAIT_1;
            2'b10:   lp_tgt = `OSC_LP_WAIT_2;
            default: lp_tgt = `OSC_LP_WAIT_3;
        endcase
    end

    // High-freq wait is 4 << code, so the smallest choice is the minimum
    assign tgt[14:0]  = `OSC_BOOT_WAIT;
    assign tgt[29:15] = lp_tgt;
    assign tgt[44:30] = `OSC_HF_WAIT_BASE << hf_wt_q;

    // ==========================================================
    // Per-oscillator stabilization wait
    // Oscillator clocks are sampled, so each must run below clk/2.
    // Counters run on clk and step on synchronized oscillator edges,
    // so a stalled oscillator simply freezes its count.
    genvar gi;
    generate
        for (gi = 0; gi < NWAIT; gi = gi + 1) begin : g_wait
            reg        s1_q;
            reg        s2_q;
            reg        s3_q;
            reg [14:0] cnt_q;
            reg        g_q;
            wire [14:0] t = tgt[gi*CW+CW-1:gi*CW];

            // Third flop only feeds the edge detector; s1 stays a pure synchroniser
            assign osc_edge[gi] = s2_q & ~s3_q;
            assign done[gi]     = run_q[gi] & ~g_q & osc_edge[gi] & (cnt_q == t - 15'h0001);
            assign gate_q[gi]   = g_q;
            assign cnt_all[gi*CW+CW-1:gi*CW] = cnt_q;

            always @(posedge clk) begin
                if (!rst_b) begin
                    // Pins idle low, so a zero reset gives no false edge
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    cnt_q <= 15'h0000;
                    g_q   <= 1'b0;
                end else begin
                    s1_q <= osc_clk_in[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (!run_q[gi]) begin
                        cnt_q <= 15'h0000;
                        g_q   <= 1'b0;
                    end else if (!g_q && osc_edge[gi]) begin
                        cnt_q <= cnt_q + 15'h0001;
                        if (done[gi]) begin
                            g_q <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // Boost timing reuses the low-power wait count
    assign lp_cnt = cnt_all[29:15];

    // ==========================================================
    // Crystal stop detector
    // The timeout spans several 32 kHz periods to tolerate jitter.
    // Armed only while the crystal runs with its clock open;
    // the internal oscillator has no detector.
    assign stop_evt = run_q[`OSC_EN_LP] & gate_q[1] & lp_stopdet_q & ~lp_type_q
                    & ~osc_edge[1] & (stop_cnt_q == STOP_CYCLES - 16'h0001);

    always @(posedge clk) begin
        if (!rst_b) begin
            stop_cnt_q <= 16'h0000;
        end else if (!(run_q[`OSC_EN_LP] & gate_q[1] & lp_stopdet_q & ~lp_type_q)
                     || osc_edge[1] || stop_evt) begin
            stop_cnt_q <= 16'h0000;
        end else begin
            stop_cnt_q <= stop_cnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // Oscillator run controls
    // A restart drops the run line for one cycle, which also reruns the wait.
    // Every encoded wait is at least the boost length, so the gain always reverts.
    // Run lines are registered so each oscillator pin comes from a flop.
    assign boost_on = run_q[`OSC_EN_LP] & lp_boost_q & ~lp_type_q
                    & (lp_cnt < `OSC_LP_BOOST_CYC);

    always @(posedge clk) begin
        if (!rst_b) begin
            run_q      <= 3'h0;
            ext_gate_q <= 1'b0;
            gain_q     <= 2'h0;
        end else begin
            run_q[`OSC_EN_BOOT] <= en_q[`OSC_EN_BOOT];
            run_q[`OSC_EN_LP]   <= en_q[`OSC_EN_LP] & ~(stop_evt & lp_restart_q);
            run_q[`OSC_EN_HF]   <= en_q[`OSC_EN_HF];
            // External clock has no counter: its gate just follows the enable
            ext_gate_q          <= en_q[`OSC_EN_EXT];
            gain_q              <= boost_on ? lp_bgain_q : lp_ngain_q;
        end
    end

    // ==========================================================
    // Register writes
    // Writing zero to a flag bit leaves it alone
    always @* begin
        flag_d = flag_q;
        if (wr_flg) begin
            flag_d = flag_d & ~reg_wdata[3:0];
        end
        // Hardware set wins over a same-cycle clear
        flag_d = flag_d | {stop_evt, done};
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            en_q         <= `OSC_EN_RST;
            lp_type_q    <= 1'b0;
            lp_wt_q      <= 2'h0;
            lp_ngain_q   <= 2'h0;
            lp_cap_q     <= 3'h0;
            lp_bgain_q   <= 2'h0;
            lp_boost_q   <= 1'b0;
            lp_stopdet_q <= 1'b0;
            lp_restart_q <= 1'b0;
            hf_fq_q      <= 1'b0;
            hf_wt_q      <= 3'h0;
            flag_q       <= 4'h0;
            ie_q         <= 4'h0;
            key_q        <= `OSC_KEY_RST;
            irq_q        <= 1'b0;
        end else begin
            if (wr_en) begin
                en_q <= reg_wdata[3:0];
            end
            // Only the two configuration words are locked
            if (wr_lp && unlocked) begin
                lp_type_q    <= reg_wdata[`OSC_LP_TYPE];
                lp_wt_q      <= reg_wdata[`OSC_LP_WT_LSB+1:`OSC_LP_WT_LSB];
                lp_ngain_q   <= reg_wdata[`OSC_LP_NGAIN_LSB+1:`OSC_LP_NGAIN_LSB];
                lp_cap_q     <= reg_wdata[`OSC_LP_CAP_LSB+2:`OSC_LP_CAP_LSB];
                lp_bgain_q   <= reg_wdata[`OSC_LP_BGAIN_LSB+1:`OSC_LP_BGAIN_LSB];
                lp_boost_q   <= reg_wdata[`OSC_LP_BOOST];
                lp_stopdet_q <= reg_wdata[`OSC_LP_STOPDET];
                lp_restart_q <= reg_wdata[`OSC_LP_RESTART];
            end
            if (wr_hf && unlocked) begin
                hf_fq_q <= reg_wdata[`OSC_HF_FQ];
                hf_wt_q <= reg_wdata[`OSC_HF_WT_LSB+2:`OSC_HF_WT_LSB];
            end
            if (wr_ie) begin
                ie_q <= reg_wdata[3:0];
            end
            // Any value but the unlock code locks again
            if (wr_key) begin
                key_q <= reg_wdata[15:0];
            end
            flag_q <= flag_d;
            // Irq lags the flags by a cycle so it stays a flop output
            irq_q  <= |(flag_q & ie_q);
        end
    end

    // ==========================================================
    // Register reads: data valid only in the cycle after the strobe
    // Status is read only; writes to it are ignored
    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr)
            `OSC_A_ENABLE: rdata_d[3:0] = en_q;
            `OSC_A_LP_CFG: begin
                rdata_d[`OSC_LP_TYPE]                         = lp_type_q;
                rdata_d[`OSC_LP_WT_LSB+1:`OSC_LP_WT_LSB]       = lp_wt_q;
                rdata_d[`OSC_LP_NGAIN_LSB+1:`OSC_LP_NGAIN_LSB] = lp_ngain_q;
                rdata_d[`OSC_LP_CAP_LSB+2:`OSC_LP_CAP_LSB]     = lp_cap_q;
                rdata_d[`OSC_LP_BGAIN_LSB+1:`OSC_LP_BGAIN_LSB] = lp_bgain_q;
                rdata_d[`OSC_LP_BOOST]                        = lp_boost_q;
                rdata_d[`OSC_LP_STOPDET]                      = lp_stopdet_q;
                rdata_d[`OSC_LP_RESTART]                      = lp_restart_q;
            end
            `OSC_A_HF_CFG: begin
                rdata_d[`OSC_HF_FQ]                       = hf_fq_q;
                rdata_d[`OSC_HF_WT_LSB+2:`OSC_HF_WT_LSB]   = hf_wt_q;
            end
            `OSC_A_FLAGS:  rdata_d[3:0]  = flag_q;
            `OSC_A_IE:     rdata_d[3:0]  = ie_q;
            `OSC_A_KEY:    rdata_d[15:0] = key_q;
            `OSC_A_STATUS: rdata_d[3:0]  = {ext_gate_q, gate_q};
            default:       rdata_d       = 32'h00000000;
        endcase
    end

    // Read data falls back to zero so a stale word never lingers
    always @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    // ==========================================================
    // Outputs
    // Gates are levels for the clock switches outside this block
    assign reg_rdata         = rdata_q;
    assign boot_osc_run      = run_q[`OSC_EN_BOOT];
    assign lowpower_osc_run  = run_q[`OSC_EN_LP];
    assign highfreq_osc_run  = run_q[`OSC_EN_HF];
    assign lowpower_type_sel = lp_type_q;
    assign lowpower_gain     = gain_q;
    assign gate_cap_sel      = lp_cap_q;
    assign highfreq_freq_sel = hf_fq_q;
    assign boot_clk_gate     = gate_q[0];
    assign lowpower_clk_gate = gate_q[1];
    assign highfreq_clk_gate = gate_q[2];
    assign ext_clk_gate      = ext_gate_q;
    assign irq               = irq_q;

endmodule // osc_start_ctrl

`default_nettype wire

//--- sim/osc_start_ctrl_chk.sv
`default_nettype none
`include "osc_regs.vh"
module osc_start_ctrl_chk #(
    parameter [14:0] LP_WAIT_LONG = 15'h4000,
    parameter [15:0] STOP_CYCLES  = 16'h8000
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        boot_osc_clock,
    input wire logic        lowpower_osc_clock,
    input wire logic        highfreq_osc_clock,
    input wire logic        boot_osc_run,
    input wire logic        lowpower_osc_run,
    input wire logic        highfreq_osc_run,
    input wire logic        lowpower_type_sel,
    input wire logic [1:0]  lowpower_gain,
    input wire logic [2:0]  gate_cap_sel,
    input wire logic        highfreq_freq_sel,
    input wire logic        boot_clk_gate,
    input wire logic        lowpower_clk_gate,
    input wire logic        highfreq_clk_gate,
    input wire logic        ext_clk_gate,
    input wire logic        irq
);
    // ==========================================================
    // Mirror of the key and of the low-power configuration written past it
    logic [15:0] key_q;
    logic [20:0] lcfg_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            key_q  <= `OSC_KEY_RST;
            lcfg_q <= 21'h000000;
        end else if (reg_wr && reg_addr == `OSC_A_KEY) begin
            key_q <= reg_wdata[15:0];
        end else if (reg_wr && reg_addr == `OSC_A_LP_CFG && key_q == `OSC_KEY_UNLOCK) begin
            lcfg_q <= reg_wdata[20:0];
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr1(a);
        reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
    endsequence
    boot_run_rst_a: assert property ($rose(rst_b) |-> ##[1:3] boot_osc_run)
        else $error("boot oscillator not running after reset");
    lp_gate_open_a: assert property ($rose(lowpower_clk_gate) |-> $past(lowpower_osc_run, 8))
        else $error("low-power clock opened without a wait");
    boot_gate_open_a: assert property ($rose(boot_clk_gate) |-> $past(boot_osc_run, 8))
        else $error("boot clock opened without a wait");
    lp_gate_close_a: assert property ($fell(lowpower_osc_run) |-> ##[0:2] !lowpower_clk_gate)
        else $error("low-power clock still open after stop");
    hf_gate_close_a: assert property (!highfreq_osc_run [*2] |-> !highfreq_clk_gate)
        else $error("high-frequency clock open while stopped");
    ext_follow_a: assert property (s_wr1(`OSC_A_ENABLE) |=>
        ext_clk_gate == $past(reg_wdata[`OSC_EN_EXT], 2))
        else $error("external clock gate does not follow its enable");
    ie_mask_a: assert property ((reg_wr && reg_addr == `OSC_A_IE && reg_wdata[3:0] == 4'h0)
        ##1 !(reg_wr && reg_addr == `OSC_A_IE) |=> !irq)
        else $error("interrupt raised with all enables off");
    cfg_lock_a: assert property ((reg_wr && reg_addr == `OSC_A_LP_CFG &&
        key_q != `OSC_KEY_UNLOCK && gate_cap_sel == lcfg_q[14:12]) |=> $stable(gate_cap_sel) [*2])
        else $error("locked configuration changed");
    cap_apply_a: assert property (s_wr1(`OSC_A_LP_CFG) |=> gate_cap_sel == lcfg_q[14:12])
        else $error("gate capacitor select wrong");
    freq_apply_a: assert property ((reg_wr && reg_addr == `OSC_A_HF_CFG &&
        key_q == `OSC_KEY_UNLOCK) ##1 !(reg_wr && reg_addr == `OSC_A_HF_CFG) |=>
        highfreq_freq_sel == $past(reg_wdata[`OSC_HF_FQ], 2))
        else $error("frequency select wrong");
    boost_a: assert property ($rose(lowpower_osc_run) && !lowpower_type_sel &&
        lcfg_q[`OSC_LP_BOOST] |-> ##[1:3] lowpower_gain == lcfg_q[17:16])
        else $error("boost gain not applied at start");
endmodule // osc_start_ctrl_chk
bind osc_start_ctrl osc_start_ctrl_chk #(
    .LP_WAIT_LONG(LP_WAIT_LONG), .STOP_CYCLES(STOP_CYCLES)
) i_chk (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_osc_clock(boot_osc_clock),
    .lowpower_osc_clock(lowpower_osc_clock), .highfreq_osc_clock(highfreq_osc_clock),
    .boot_osc_run(boot_osc_run), .lowpower_osc_run(lowpower_osc_run),
    .highfreq_osc_run(highfreq_osc_run), .lowpower_type_sel(lowpower_type_sel),
    .lowpower_gain(lowpower_gain), .gate_cap_sel(gate_cap_sel),
    .highfreq_freq_sel(highfreq_freq_sel), .boot_clk_gate(boot_clk_gate),
    .lowpower_clk_gate(lowpower_clk_gate), .highfreq_clk_gate(highfreq_clk_gate),
    .ext_clk_gate(ext_clk_gate), .irq(irq)
);
`default_nettype wire

//--- sim/osc_start_ctrl_tb.sv
`default_nettype none
`include "osc_regs.vh"
module osc_start_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [2:0]  oclk = 3'h0;
    logic        lp_dead = 1'b0;
    logic [31:0] reg_rdata, rv, lcfg;
    logic [2:0]  run, gate, cap, hcode;
    logic [1:0]  gain, bgain;
    logic        ext_gate, irq, type_sel, fq;
    int          ecnt [3] = '{0, 0, 0};
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // ==========================================================
    // Clocks: oscillators stand still while not running
    always #2 clk = ~clk;
    always #9.3 oclk[0] = run[0] ? ~oclk[0] : 1'b0;
    // lp_dead stalls the low-power oscillator to trip the stop detector
    always #13.1 oclk[1] = (run[1] && !lp_dead) ? ~oclk[1] : 1'b0;
    always #11.7 oclk[2] = run[2] ? ~oclk[2] : 1'b0;
    always @(posedge oclk[0]) ecnt[0]++;
    always @(posedge oclk[1]) ecnt[1]++;
    always @(posedge oclk[2]) ecnt[2]++;
    osc_start_ctrl #(.LP_WAIT_LONG(15'h0040), .STOP_CYCLES(16'h0040)) i_dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .boot_osc_clock(oclk[0]), .lowpower_osc_clock(oclk[1]), .highfreq_osc_clock(oclk[2]),
        .boot_osc_run(run[0]), .lowpower_osc_run(run[1]), .highfreq_osc_run(run[2]),
        .lowpower_type_sel(type_sel), .lowpower_gain(gain), .gate_cap_sel(cap),
        .highfreq_freq_sel(fq), .boot_clk_gate(gate[0]), .lowpower_clk_gate(gate[1]),
        .highfreq_clk_gate(gate[2]), .ext_clk_gate(ext_gate), .irq(irq)
    );
    // ==========================================================
    // Tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Base count taken before the enable write, so no early edge is lost;
    // the boot oscillator runs from reset, so all its edges count
    task automatic start(input int i, input logic [3:0] en, input int n);
        int b;
        b = (i == 0) ? 0 : ecnt[i];
        if (i != 0) wr(`OSC_A_ENABLE, {28'h0, en});
        while (ecnt[i] < b + n - 1) @(posedge clk);
        rd(`OSC_A_STATUS, rv);
        chk(rv[i], 1'b0);
        while (ecnt[i] < b + n) @(posedge clk);
        repeat (6) @(posedge clk);
        rd(`OSC_A_STATUS, rv);
        chk(rv[i], 1'b1);
        rd(`OSC_A_FLAGS, rv);
        chk(rv[i], 1'b1);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hb0e1));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(`OSC_A_ENABLE, rv);
        chk(rv, 32'h1);
        rd(`OSC_A_KEY, rv);
        chk(rv, 32'h0);
        start(0, 4'h0, 16);
        rd(8'h1c, rv);
        chk(rv, 32'h0);
        $display("test reset done");
        bgain = 2'($urandom);
        lcfg = {11'h0, 1'b1, 2'h0, bgain, 1'b0, 3'($urandom), 2'h0, 2'($urandom), 8'h00};
        wr(`OSC_A_LP_CFG, lcfg);
        rd(`OSC_A_LP_CFG, rv);
        chk(rv, 32'h0);
        wr(`OSC_A_KEY, 32'h96);
        wr(`OSC_A_LP_CFG, lcfg | 32'h1);
        @(posedge clk);
        chk(type_sel, 1'b1);
        wr(`OSC_A_LP_CFG, lcfg);
        wr(`OSC_A_KEY, 32'h0);
        wr(`OSC_A_LP_CFG, 32'h1);
        rd(`OSC_A_LP_CFG, rv);
        chk(rv, lcfg);
        chk(cap, lcfg[14:12]);
        chk(type_sel, 1'b0);
        $display("test protect done");
        wr(`OSC_A_FLAGS, 32'hf);
        wr(`OSC_A_IE, 32'h2);
        start(1, 4'h3, 64);
        chk(gain, bgain);
        chk(irq, 1'b1);
        wr(`OSC_A_ENABLE, 32'h1);
        @(posedge clk);
        rd(`OSC_A_STATUS, rv);
        chk(rv[1], 1'b0);
        start(1, 4'h3, 64);
        wr(`OSC_A_IE, 32'h0);
        @(posedge clk);
        chk(irq, 1'b0);
        wr(`OSC_A_IE, 32'h2);
        @(posedge clk);
        chk(irq, 1'b1);
        wr(`OSC_A_FLAGS, 32'h2);
        @(posedge clk);
        chk(irq, 1'b0);
        rd(`OSC_A_FLAGS, rv);
        chk(rv[1], 1'b0);
        $display("test lowpower done");
        wr(`OSC_A_KEY, 32'h96);
        wr(`OSC_A_LP_CFG, lcfg | 32'h03000000);
        wr(`OSC_A_KEY, 32'h0);
        repeat (120) @(posedge clk);
        rd(`OSC_A_FLAGS, rv);
        chk(rv[3], 1'b0);
        lp_dead <= 1'b1;
        repeat (120) @(posedge clk);
        rd(`OSC_A_FLAGS, rv);
        chk(rv[3], 1'b1);
        rd(`OSC_A_STATUS, rv);
        chk(rv[1], 1'b0);
        lp_dead <= 1'b0;
        $display("test stopdet done");
        hcode = 3'($urandom_range(2));
        rv = {25'h0, hcode, 3'h0, 1'($urandom)};
        wr(`OSC_A_KEY, 32'h96);
        wr(`OSC_A_HF_CFG, rv);
        wr(`OSC_A_KEY, 32'h0);
        chk(fq, rv[0]);
        start(2, 4'h5, 4 << hcode);
        wr(`OSC_A_ENABLE, 32'hd);
        @(posedge clk);
        chk(ext_gate, 1'b1);
        rd(`OSC_A_STATUS, rv);
        chk(rv[3], 1'b1);
        $display("test highfreq done");
        summarize();
    end
endmodule // osc_start_ctrl_tb
`default_nettype wire
